// [rtl/tmr_pkg.sv]
/*
  tmr_pkg: register map, field layout, reset values and mode codes
  for the reloading 16-bit timer.
  assumes: APB byte addresses, one register per aligned 32-bit word.
*/
package tmr_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_COUNT_HIGH  = 8'h00;
  localparam logic [7:0] OFF_COUNT_LOW   = 8'h04;
  localparam logic [7:0] OFF_RELOAD_HIGH = 8'h08;
  localparam logic [7:0] OFF_RELOAD_LOW  = 8'h0c;
  localparam logic [7:0] OFF_CONTROL_0   = 8'h10;
  localparam logic [7:0] OFF_CONTROL_1   = 8'h14;
  localparam logic [7:0] OFF_INT_STATUS  = 8'h18;
  localparam logic [7:0] OFF_INT_MASK    = 8'h1c;
  localparam logic [7:0] OFF_CAPTURE     = 8'h20;

  // control 0 fields
  localparam int CTL0_MODE_HIGH_BIT = 7;
  localparam int CTL0_OUT_EN_BIT    = 0;

  // interrupt status bits
  localparam int IRQ_RELOAD_BIT  = 0;
  localparam int IRQ_CAPTURE_BIT = 1;
  localparam int IRQ_WIDTH       = 2;

  // reset values
  localparam logic [15:0] COUNT_RESET   = 16'h0001;
  localparam logic [15:0] RELOAD_RESET  = 16'hffff;
  localparam logic [15:0] COUNT_RESTART = 16'h0001;
  localparam logic [7:0]  CTL_RESET     = 8'h00;

  // control 1 layout, msb first
  typedef struct packed {
    logic       enable;
    logic       input_polarity_bit;
    logic [2:0] prescale_select;
    logic [2:0] mode_select_low;
  } tmr_ctl1_type;

  // full mode value {mode_select_high, mode_select_low}
  typedef enum logic [3:0] {
    MODE_ONE_SHOT        = 4'b0000,
    MODE_CONTINUOUS      = 4'b0001,
    MODE_COUNTER         = 4'b0010,
    MODE_CAPTURE_RESTART = 4'b1000
  } tmr_mode_type;

endpackage

// [rtl/tmr_timer.sv]
/*
  tmr_timer: 16-bit reloading timer with continuous, counter and
  capture-restart modes, APB register slave and one level interrupt.
  assumes: single clock pclk, async active-low presetn, timer input
  arrives from a pin in another clock domain.
*/
// Our own choices: the address map and the APB register port.
// What this block does
// - continuous mode: written start count used once, later passes restart at 0001H
// - continuous mode counts prescaled system clock, never the pin
// - continuous period after first equals reload times prescale divisor
// - first continuous pass counts from loaded start up to reload
// - counter mode increments on transitions of the timer input pin
// - polarity bit picks rising or falling input edge in counter mode
// - counter mode bypasses prescaler, one count per qualifying edge
// - counter mode at reload: interrupt, count back to 0001H, keep counting
// - output pin inverts at every reload when its function is enabled
// - capture-restart: polarity 0 captures on rising, 1 on falling edge
// - prescaler divides by two to the three-bit prescale code, 1 to 128
// - prescaler is cleared while the timer is disabled
// - four-bit mode is control 0 high bit plus control 1 low bits
// - disabled: output follows polarity; enabled: toggles at each reload
`timescale 1ns/1ps

module tmr_timer (
  input  wire logic        pclk,            // system clock, 100 MHz
  input  wire logic        presetn,         // async reset, active low
  input  wire logic        psel,            // apb select
  input  wire logic        penable,         // apb access phase
  input  wire logic        pwrite,          // apb direction
  input  wire logic [7:0]  paddr,           // apb byte address
  input  wire logic [31:0] pwdata,          // apb write data
  output logic      [31:0] prdata,          // apb read data
  output logic             pready,          // apb ready
  output logic             pslverr,         // apb error, unmapped address
  input  wire logic        timer_input_pin, // external timer input
  output logic             timer_output_pin,   // timer output level
  output logic             timer_output_oe_n,  // low while pin driven
  output logic             irq              // level interrupt
);

  // register state
  logic [15:0]               count_q;
  logic [15:0]               reload_q;
  logic [15:0]               capture_q;
  logic [7:0]                ctl0_q;
  tmr_pkg::tmr_ctl1_type     ctl1_q;
  logic [tmr_pkg::IRQ_WIDTH-1:0] status_q;
  logic [tmr_pkg::IRQ_WIDTH-1:0] mask_q;
  logic [6:0]                presc_q;
  logic                      in_meta_q;
  logic                      in_sync_q;
  logic                      in_prev_q;
  logic                      out_level_q;

  // bus decode
  logic        wr_en;
  logic        rd_setup;
  logic        addr_hit;
  logic [31:0] rd_word;

  // timer datapath
  tmr_pkg::tmr_mode_type mode;
  logic [6:0]  presc_mask;
  logic        presc_tick;
  logic        in_edge;
  logic        step;
  logic        at_reload;
  logic        reload_evt;
  logic        capture_evt;
  logic [tmr_pkg::IRQ_WIDTH-1:0] set_bits;

  // write takes effect only at the edge where ready is sampled high
  assign wr_en    = psel & penable & pready & pwrite;
  assign rd_setup = psel & ~penable;

  // mode assembled from the two control registers
  assign mode = tmr_pkg::tmr_mode_type'({ctl0_q[tmr_pkg::CTL0_MODE_HIGH_BIT],
                                        ctl1_q.mode_select_low});

  // divide by 2**code: tick when the low code bits are all ones
  assign presc_mask = 7'((8'h01 << ctl1_q.prescale_select) - 8'h01);
  assign presc_tick = ((presc_q & presc_mask) == presc_mask);

  // edge detect reads only the second synchroniser stage
  assign in_edge = ctl1_q.input_polarity_bit ? (in_prev_q & ~in_sync_q)
                                             : (~in_prev_q & in_sync_q);

  // count source per mode
  always_comb begin
    step        = 1'b0;
    capture_evt = 1'b0;
    case (mode)
      tmr_pkg::MODE_CONTINUOUS: begin
        step = ctl1_q.enable & presc_tick;
      end
      tmr_pkg::MODE_COUNTER: begin
        step = ctl1_q.enable & in_edge;
      end
      tmr_pkg::MODE_CAPTURE_RESTART: begin
        step        = ctl1_q.enable & presc_tick;
        capture_evt = ctl1_q.enable & in_edge;
      end
      default: begin
        step        = 1'b0;
        capture_evt = 1'b0;
      end
    endcase
  end

  assign at_reload  = (count_q == reload_q);
  assign reload_evt = step & at_reload & ~capture_evt;

  // input synchroniser, then previous sample for edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_meta_q <= 1'b0;
      in_sync_q <= 1'b0;
      in_prev_q <= 1'b0;
    end else begin
      in_meta_q <= timer_input_pin;
      in_sync_q <= in_meta_q;
      in_prev_q <= in_sync_q;
    end
  end

  // prescaler, held clear while disabled so each start divides cleanly
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_q <= 7'h00;
    end else if (!ctl1_q.enable) begin
      presc_q <= 7'h00;
    end else begin
      presc_q <= presc_q + 7'h01;
    end
  end

  // count: software byte writes win over the running count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= tmr_pkg::COUNT_RESET;
    end else if (wr_en && paddr == tmr_pkg::OFF_COUNT_HIGH) begin
      count_q[15:8] <= pwdata[7:0];
    end else if (wr_en && paddr == tmr_pkg::OFF_COUNT_LOW) begin
      count_q[7:0] <= pwdata[7:0];
    end else if (capture_evt) begin
      count_q <= tmr_pkg::COUNT_RESTART;
    end else if (reload_evt) begin
      // start value only shapes the first pass
      count_q <= tmr_pkg::COUNT_RESTART;
    end else if (step) begin
      count_q <= count_q + 16'h0001;
    end
  end

  // capture register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_q <= 16'h0000;
    end else if (capture_evt) begin
      capture_q <= count_q;
    end
  end

  // reload register, byte halves
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reload_q <= tmr_pkg::RELOAD_RESET;
    end else if (wr_en && paddr == tmr_pkg::OFF_RELOAD_HIGH) begin
      reload_q[15:8] <= pwdata[7:0];
    end else if (wr_en && paddr == tmr_pkg::OFF_RELOAD_LOW) begin
      reload_q[7:0] <= pwdata[7:0];
    end
  end

  // control registers; enable is expected to be written last
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl0_q <= tmr_pkg::CTL_RESET;
      ctl1_q <= tmr_pkg::tmr_ctl1_type'(tmr_pkg::CTL_RESET);
    end else begin
      if (wr_en && paddr == tmr_pkg::OFF_CONTROL_0) begin
        ctl0_q <= pwdata[7:0];
      end
      if (wr_en && paddr == tmr_pkg::OFF_CONTROL_1) begin
        ctl1_q <= tmr_pkg::tmr_ctl1_type'(pwdata[7:0]);
      end
    end
  end

  // output level: follows polarity when idle, toggles on reload.
  // polarity changes while running do not move the level at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_level_q <= 1'b0;
    end else if (!ctl1_q.enable) begin
      out_level_q <= ctl1_q.input_polarity_bit;
    end else if (reload_evt) begin
      out_level_q <= ~out_level_q;
    end
  end

  // pin drive registered so the port comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_output_pin  <= 1'b0;
      timer_output_oe_n <= 1'b1;
    end else begin
      timer_output_pin  <= out_level_q;
      timer_output_oe_n <= ~ctl0_q[tmr_pkg::CTL0_OUT_EN_BIT];
    end
  end

  // sticky status; a new event beats a write-one clear
  assign set_bits = {capture_evt, reload_evt};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= '0;
    end else if (wr_en && paddr == tmr_pkg::OFF_INT_STATUS) begin
      status_q <= (status_q & ~pwdata[tmr_pkg::IRQ_WIDTH-1:0]) | set_bits;
    end else begin
      status_q <= status_q | set_bits;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= '0;
    end else if (wr_en && paddr == tmr_pkg::OFF_INT_MASK) begin
      mask_q <= pwdata[tmr_pkg::IRQ_WIDTH-1:0];
    end
  end

  // interrupt level, one cycle behind the status bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_q & mask_q);
    end
  end

  // read mux; unmapped addresses read zero and flag an error
  always_comb begin
    rd_word  = 32'h0000_0000;
    addr_hit = 1'b1;
    case (paddr)
      tmr_pkg::OFF_COUNT_HIGH:  rd_word[7:0] = count_q[15:8];
      tmr_pkg::OFF_COUNT_LOW:   rd_word[7:0] = count_q[7:0];
      tmr_pkg::OFF_RELOAD_HIGH: rd_word[7:0] = reload_q[15:8];
      tmr_pkg::OFF_RELOAD_LOW:  rd_word[7:0] = reload_q[7:0];
      tmr_pkg::OFF_CONTROL_0:   rd_word[7:0] = ctl0_q;
      tmr_pkg::OFF_CONTROL_1:   rd_word[7:0] = ctl1_q;
      tmr_pkg::OFF_INT_STATUS:
        rd_word[tmr_pkg::IRQ_WIDTH-1:0] = status_q;
      tmr_pkg::OFF_INT_MASK:
        rd_word[tmr_pkg::IRQ_WIDTH-1:0] = mask_q;
      tmr_pkg::OFF_CAPTURE:     rd_word[15:0] = capture_q;
      default:                  addr_hit = 1'b0;
    endcase
  end

  // no wait states: answer is registered during the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= rd_setup;
      pslverr <= rd_setup & ~addr_hit;
      prdata  <= (rd_setup && !pwrite) ? rd_word : 32'h0000_0000;
    end
  end

endmodule

// [testbench/tmr_src.sv]
/* tmr_src: external source on the timer input pin.
   assumes: bench pulses go for one clock, then waits on busy. */
`timescale 1ns/1ps
module tmr_src (
  input  wire logic       pclk,  // system clock
  input  wire logic       go,    // start a burst
  input  wire logic [7:0] n_tog, // transitions wanted
  output logic            pin,   // timer input level
  output logic            busy   // burst running
);
  logic [7:0] left_q = 8'h00;
  logic [1:0] ph_q   = 2'h0;
  logic       pin_q  = 1'b0;
  logic       busy_q = 1'b0;
  // each level held three clocks, above the two-clock floor
  always_ff @(posedge pclk) begin
    if (go && !busy_q) begin
      left_q <= n_tog;
      ph_q   <= 2'h0;
      busy_q <= n_tog != 8'h00;
    end else if (busy_q) begin
      ph_q <= ph_q + 2'h1;
      if (ph_q == 2'h2) begin
        pin_q  <= ~pin_q;
        ph_q   <= 2'h0;
        left_q <= left_q - 8'h01;
        busy_q <= left_q != 8'h01;
      end
    end
  end
  assign pin  = pin_q;
  assign busy = busy_q;
endmodule

// [testbench/tmr_timer_bench.sv]
/* tmr_timer_bench: register-level tests of tmr_timer.
   assumes: tmr_src drives the timer input pin. */
`timescale 1ns/1ps
module tmr_timer_bench;
  logic        pclk, presetn, psel, penable, pwrite, go, t_out, oe_n;
  logic        pready, pslverr, pin, busy, irq, err;
  logic [7:0]  paddr, n_tog;
  logic [31:0] pwdata, prdata, rd;
  int          bad_count = 0, n_compared = 0, cyc = 0, n;

  tmr_timer DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_input_pin(pin), .timer_output_pin(t_out),
    .timer_output_oe_n(oe_n), .irq(irq));
  tmr_src u_src (.pclk(pclk), .go(go), .n_tog(n_tog), .pin(pin),
    .busy(busy));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task give_verdict;
    $display("compared %0d mismatched %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // hang guard, well above the few thousand cycles needed
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      bad_count++;
      give_verdict();
    end
  end

  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask

  // one apb transfer, then three clocks for registered outputs to settle
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // pin level lags a control write by two flops, so wait three edges
    repeat (3) @(posedge pclk);
  endtask

  task rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask

  task burst(input logic [7:0] k);
    @(posedge pclk);
    n_tog <= k;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    do @(posedge pclk); while (busy);
    repeat (6) @(posedge pclk);
  endtask

  // clocks until the timer output next changes
  task tog;
    logic l;
    l = t_out;
    n = 0;
    do begin @(posedge pclk); n++; end while (t_out === l);
  endtask

  initial begin
    {psel, penable, pwrite, go, presetn} = 5'h0;
    paddr = 8'h00; pwdata = 32'h0; n_tog = 8'h00;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rchk("count_low", tmr_pkg::OFF_COUNT_LOW, 32'h1);
    rchk("reload_high", tmr_pkg::OFF_RELOAD_HIGH, 32'hff);
    rchk("control_1", tmr_pkg::OFF_CONTROL_1, 32'h0);
    xfer(1'b0, 8'h24, 32'h0);
    chk("unmapped_err", 32'h1, err);
    // configure fully, enable last
    xfer(1'b1, tmr_pkg::OFF_COUNT_HIGH, 32'h0);
    xfer(1'b1, tmr_pkg::OFF_COUNT_LOW, 32'h3);
    xfer(1'b1, tmr_pkg::OFF_RELOAD_HIGH, 32'h0);
    xfer(1'b1, tmr_pkg::OFF_RELOAD_LOW, 32'h3);
    xfer(1'b1, tmr_pkg::OFF_INT_MASK, 32'h1);
    xfer(1'b1, tmr_pkg::OFF_CONTROL_0, 32'h1);
    chk("oe_n", 32'h0, oe_n);
    // pin toggles meanwhile; continuous mode must ignore it
    go <= 1'b1;
    n_tog <= 8'd254;
    @(posedge pclk);
    go <= 1'b0;
    for (int p = 0; p < 8; p++) begin
      xfer(1'b1, tmr_pkg::OFF_CONTROL_1, 32'h0);
      xfer(1'b1, tmr_pkg::OFF_CONTROL_1, 32'h81 | (p << 3));
      tog();
      tog();
      chk("period", 32'h3 << p, n);
    end
    xfer(1'b1, tmr_pkg::OFF_CONTROL_1, 32'h40);
    chk("out_pol1", 32'h1, t_out);
    xfer(1'b1, tmr_pkg::OFF_CONTROL_1, 32'h0);
    chk("out_pol0", 32'h0, t_out);
    do @(posedge pclk); while (busy);
    xfer(1'b1, tmr_pkg::OFF_COUNT_LOW, 32'h1);
    xfer(1'b1, tmr_pkg::OFF_RELOAD_LOW, 32'h4);
    xfer(1'b1, tmr_pkg::OFF_INT_STATUS, 32'h3);
    // counter mode, rising edges, prescale code 7 left set
    xfer(1'b1, tmr_pkg::OFF_CONTROL_1, 32'hba);
    burst(8'd6);
    rchk("count_3_rises", tmr_pkg::OFF_COUNT_LOW, 32'h4);
    chk("irq_before", 32'h0, irq);
    burst(8'd2);
    rchk("count_reload", tmr_pkg::OFF_COUNT_LOW, 32'h1);
    rchk("status", tmr_pkg::OFF_INT_STATUS, 32'h1);
    chk("irq_set", 32'h1, irq);
    xfer(1'b1, tmr_pkg::OFF_INT_MASK, 32'h0);
    chk("irq_masked", 32'h0, irq);
    xfer(1'b1, tmr_pkg::OFF_INT_MASK, 32'h1);
    xfer(1'b1, tmr_pkg::OFF_INT_STATUS, 32'h1);
    chk("irq_cleared", 32'h0, irq);
    // falling edges only: a rise must not count
    xfer(1'b1, tmr_pkg::OFF_CONTROL_1, 32'hfa);
    burst(8'd1);
    rchk("count_rise_pol1", tmr_pkg::OFF_COUNT_LOW, 32'h1);
    burst(8'd1);
    rchk("count_fall_pol1", tmr_pkg::OFF_COUNT_LOW, 32'h2);
    // capture-restart, polarity 0: a rise captures the running count
    xfer(1'b1, tmr_pkg::OFF_CONTROL_0, 32'h81);
    xfer(1'b1, tmr_pkg::OFF_CONTROL_1, 32'h80);
    xfer(1'b1, tmr_pkg::OFF_INT_STATUS, 32'h3);
    burst(8'd1);
    xfer(1'b0, tmr_pkg::OFF_INT_STATUS, 32'h0);
    chk("capture_flag", 32'h2, rd & 32'h2);
    xfer(1'b0, tmr_pkg::OFF_CAPTURE, 32'h0);
    chk("capture_range", 32'h1, 32'(rd >= 32'h1 && rd <= 32'h4));
    give_verdict();
  end
endmodule

// [testbench/tmr_timer_props.sv]
/* tmr_timer_props: port checker for tmr_timer, bound below.
   assumes: one clock pclk, presetn async active low. */
`timescale 1ns/1ps
module tmr_timer_props (
  input wire logic        pclk,              // clock
  input wire logic        presetn,           // reset
  input wire logic        psel,              // apb
  input wire logic        penable,           // apb
  input wire logic        pwrite,            // apb
  input wire logic [7:0]  paddr,             // apb
  input wire logic [31:0] pwdata,            // apb
  input wire logic [31:0] prdata,            // apb
  input wire logic        pready,            // apb
  input wire logic        pslverr,           // apb
  input wire logic        timer_input_pin,   // pin in
  input wire logic        timer_output_pin,  // pin out
  input wire logic        timer_output_oe_n, // pin enable
  input wire logic        irq                // interrupt
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // slave answers in the cycle right after setup
  property p_rdy; psel && !penable |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready after setup");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("ready held too long");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_idle; !pready |-> prdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("read data outside access");
  property p_unm; psel && !penable && paddr > 8'h20 |=> pslverr; endproperty
  a_unm: assert property (p_unm) else $error("unmapped not refused");
  property p_map;
    psel && !penable && paddr[1:0] == 2'h0 && paddr <= 8'h20 |=> !pslverr;
  endproperty
  a_map: assert property (p_map) else $error("mapped access refused");
  // output enable moves only after a control 0 write
  property p_oe;
    $changed(timer_output_oe_n) |->
      $past(psel && pwrite && paddr == tmr_pkg::OFF_CONTROL_0, 2);
  endproperty
  a_oe: assert property (p_oe) else $error("enable moved alone");
  property p_irq; $fell(irq) |-> $past(psel && pwrite, 2); endproperty
  a_irq: assert property (p_irq) else $error("irq fell alone");
endmodule

bind tmr_timer tmr_timer_props u_props (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .timer_input_pin,
  .timer_output_pin, .timer_output_oe_n, .irq);
